// file: src/ldo_defs.svh
// register offsets, field positions and reset values of the regulator block
`ifndef LDO_DEFS_SVH
`define LDO_DEFS_SVH
// =====================================================================
// register map: word indices, byte address is four times the index
`define LDO_CTRL_IDX 8'hC9
`define LDO_IRQ_IDX 8'hCC
`define LDO_CTRL_ADDR {`LDO_CTRL_IDX, 2'h0}
`define LDO_IRQ_ADDR {`LDO_IRQ_IDX, 2'h0}
// =====================================================================
// control register fields
`define LDO_OFF_BIT 7
`define LDO_RSVD_BIT 6
`define LDO_LEVEL_BIT 4
`define LDO_DROP_BIT 0
// =====================================================================
// interrupt control register fields
`define LDO_IEN_BIT 0
`define LDO_IPRI_BIT 1
// =====================================================================
// reset values
`define LDO_OFF_RST 1'h0
`define LDO_LEVEL_RST 1'h1
`define LDO_IEN_RST 1'h0
`define LDO_IPRI_RST 1'h0
`endif

// file: src/ldo_pkg.sv
// types shared by the regulator control block
package ldo_pkg;
	// bus access phase tracker
	typedef enum logic [1:0] {
		LDO_IDLE = 2'h1,
		LDO_DATA = 2'h2
	} ldo_phase_e;
	// output level choices
	typedef enum logic {
		LDO_LOW_LVL = 1'h0,
		LDO_HIGH_LVL = 1'h1
	} ldo_level_e;
endpackage

// file: src/ldo_sync.sv
// two-stage synchroniser for the analog dropout comparator
`timescale 1ns/10ps
module ldo_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic async_in,
	output logic sync_out
);
	logic meta; // first stage, read only by the second
	// =====================================================================
	// synchroniser stages
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= 1'h0;
			sync_out <= 1'h0;
		end else if (ce) begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule // ldo_sync

// file: src/ldo_ctrl.sv
// regulator control and dropout status with AHB-Lite register slave
`timescale 1ns/10ps
`include "ldo_defs.svh"
// Behaviour
// - regulator off bit 7, resets 0
// - level select bit 4, resets 1
// - bit 6 reads 1, software writes 1
// - bits 3 to 1 read zero
// - bit 5 reads zero, writes ignored
// - bit 0 shows live dropout, read-only
// - dropout irq only while enable set
// - irq has no pending flag
module ldo_ctrl
	import ldo_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [9:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic dropout_cmp,
	output logic regulator_off,
	output logic output_level_select,
	output logic dropout_irq,
	output logic dropout_irq_priority
);
	// =====================================================================
	// state
	logic drop_sync; // synchronised comparator level
	logic dropout_irq_enable; // interrupt enable bit
	logic wr_pend; // write data phase pending
	logic [9:0] wr_addr; // address captured in address phase
	logic ctrl_rd_start; // control register read in address phase
	logic next_start; // valid transfer in address phase
	ldo_phase_e phase; // data phase tracker

	// control register image as software sees it
	function automatic logic [31:0] ctrl_image(input logic off,
		input logic lvl, input logic drop);
		logic [31:0] v;
		v = 32'h0;
		v[`LDO_OFF_BIT] = off;
		v[`LDO_RSVD_BIT] = 1'h1;
		v[`LDO_LEVEL_BIT] = lvl;
		v[`LDO_DROP_BIT] = drop;
		return v;
	endfunction

	// =====================================================================
	// comparator crossing
	ldo_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(clk_en),
		.async_in(dropout_cmp),
		.sync_out(drop_sync)
	);

	// =====================================================================
	// bus address phase decode
	always_comb begin
		next_start = hsel && hready && htrans[1];
		// only the control register carries the fixed and live bits
		ctrl_rd_start = next_start && !hwrite && haddr == `LDO_CTRL_ADDR;
	end

	// ready from the first enabled clock after reset, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'h0;
			hresp <= 1'h0;
		end else if (clk_en) begin
			hreadyout <= 1'h1;
			hresp <= 1'h0;
		end
	end

	// capture write address for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'h0;
			wr_addr <= 10'h000;
			phase <= LDO_IDLE;
		end else if (clk_en) begin
			wr_pend <= next_start && hwrite;
			wr_addr <= haddr;
			phase <= next_start ? LDO_DATA : LDO_IDLE;
		end
	end

	// =====================================================================
	// writable controls; bits 6,5,3:1 and 0 ignore writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			regulator_off <= `LDO_OFF_RST;
			output_level_select <= `LDO_LEVEL_RST;
			dropout_irq_enable <= `LDO_IEN_RST;
			dropout_irq_priority <= `LDO_IPRI_RST;
		end else if (clk_en && wr_pend) begin
			if (wr_addr == `LDO_CTRL_ADDR) begin
				regulator_off <= hwdata[`LDO_OFF_BIT];
				output_level_select <= hwdata[`LDO_LEVEL_BIT];
			end else if (wr_addr == `LDO_IRQ_ADDR) begin
				dropout_irq_enable <= hwdata[`LDO_IEN_BIT];
				dropout_irq_priority <= hwdata[`LDO_IPRI_BIT];
			end
		end
	end

	// =====================================================================
	// read data, registered during address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (clk_en) begin
			if (ctrl_rd_start) begin
				hrdata <= ctrl_image(regulator_off, output_level_select,
					drop_sync);
			end else if (next_start && !hwrite && haddr == `LDO_IRQ_ADDR) begin
				hrdata <= {30'h0, dropout_irq_priority, dropout_irq_enable};
			end else begin
				hrdata <= 32'h0;
			end
		end
	end

	// =====================================================================
	// live interrupt request, no pending state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dropout_irq <= 1'h0;
		end else if (clk_en) begin
			dropout_irq <= drop_sync && dropout_irq_enable;
		end
	end

	// =====================================================================
	// checks
	property p_irq_follows;
		@(posedge hclk) disable iff (!hresetn)
		clk_en |=> (dropout_irq == ($past(drop_sync)
			&& $past(dropout_irq_enable)));
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("irq does not follow dropout and enable");

	property p_irq_clears;
		@(posedge hclk) disable iff (!hresetn)
		(!drop_sync && clk_en) |=> !dropout_irq;
	endproperty
	a_irq_clears: assert property (p_irq_clears)
		else $error("irq held without dropout");

	property p_rsvd_one;
		@(posedge hclk) disable iff (!hresetn)
		(ctrl_rd_start && clk_en)
		|=> hrdata[`LDO_RSVD_BIT] && !hrdata[5] && hrdata[3:1] == 3'h0;
	endproperty
	a_rsvd_one: assert property (p_rsvd_one)
		else $error("control readback bits wrong");

	property p_unused_zero;
		@(posedge hclk) disable iff (!hresetn)
		(ctrl_rd_start && clk_en) |=> hrdata[3:1] == 3'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("bits 3 to 1 not zero");

	property p_bit5_zero;
		@(posedge hclk) disable iff (!hresetn)
		!hrdata[5];
	endproperty
	a_bit5_zero: assert property (p_bit5_zero)
		else $error("bit 5 not zero");

	property p_drop_read;
		@(posedge hclk) disable iff (!hresetn)
		(next_start && !hwrite && haddr == `LDO_CTRL_ADDR && clk_en)
		|=> hrdata[`LDO_DROP_BIT] == $past(drop_sync);
	endproperty
	a_drop_read: assert property (p_drop_read)
		else $error("dropout bit not live");

	property p_off_write;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend && clk_en && wr_addr == `LDO_CTRL_ADDR)
		|=> regulator_off == $past(hwdata[`LDO_OFF_BIT]);
	endproperty
	a_off_write: assert property (p_off_write)
		else $error("regulator off not written");

	property p_level_write;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend && clk_en && wr_addr == `LDO_CTRL_ADDR)
		|=> output_level_select == $past(hwdata[`LDO_LEVEL_BIT]);
	endproperty
	a_level_write: assert property (p_level_write)
		else $error("level select not written");

	property p_sync_delay;
		@(posedge hclk) disable iff (!hresetn)
		clk_en ##1 clk_en |=> drop_sync == $past(dropout_cmp, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("sync delay not two cycles");

	// read data stands only in the data phase
	property p_data_only;
		@(posedge hclk) disable iff (!hresetn)
		(phase != LDO_DATA) |-> hrdata == 32'h0;
	endproperty
	a_data_only: assert property (p_data_only)
		else $error("read data outside data phase");

	// a low clock enable freezes controls, request and read data
	property p_freeze;
		@(posedge hclk) disable iff (!hresetn)
		!clk_en |=> $stable(regulator_off) && $stable(output_level_select)
			&& $stable(dropout_irq) && $stable(hrdata);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");
endmodule // ldo_ctrl

// file: sim/tb.sv
// self-checking bench for the regulator control block
`timescale 1ns/10ps
`include "ldo_defs.svh"
module tb import ldo_pkg::*;;
	// =============================================================
	// signals
	logic hclk, hresetn, hsel, hwrite, dropout_cmp, clk_en;
	logic [9:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, r, d;
	logic hreadyout, hresp, regulator_off, output_level_select;
	logic dropout_irq, dropout_irq_priority;
	int err_count, comparisons, cycles;
	int m_off, m_lvl, m_drop, m_ien, m_pri; // behavioural model state
	// =============================================================
	// design, clock enable driven by the bench and dropped low for the freeze check
	ldo_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.dropout_cmp(dropout_cmp), .regulator_off(regulator_off),
		.output_level_select(output_level_select),
		.dropout_irq(dropout_irq),
		.dropout_irq_priority(dropout_irq_priority));
	// =============================================================
	// clock and hang guard
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count++;
			results();
		end
	end
	// =============================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one single transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [9:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check(hresp, 1'b0);
	endtask
	// expected control register read from the model
	function automatic logic [31:0] ctrl_exp();
		return {24'h0, m_off[0], 1'b1, 1'b0, m_lvl[0], 3'h0, m_drop[0]};
	endfunction
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// =============================================================
	// main sequence
	initial begin
		{hsel, hwrite, dropout_cmp, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		clk_en = 1'b1;
		hresetn = 1'b0;
		{err_count, comparisons, cycles, m_off, m_drop, m_ien, m_pri} = '0;
		m_lvl = 1;
		void'($urandom(32'haf9e9b41));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values of the control register
		xfer(1'b0, `LDO_CTRL_ADDR, 32'h0, r);
		check(r, ctrl_exp());
		check(output_level_select, 1'b1);
		check(regulator_off, 1'b0);
		// random control writes; reserved bit always written as one
		repeat (8) begin
			d = $urandom;
			d[6] = 1'b1;
			xfer(1'b1, `LDO_CTRL_ADDR, d, r);
			m_off = d[7];
			m_lvl = d[4];
			xfer(1'b0, `LDO_CTRL_ADDR, 32'h0, r);
			check(r, ctrl_exp());
			check(regulator_off, m_off[0]);
			check(output_level_select, m_lvl[0]);
		end
		// unmapped place reads zero and leaves the control alone
		xfer(1'b1, {8'hC8, 2'h0}, $urandom, r);
		xfer(1'b0, {8'hC8, 2'h0}, 32'h0, r);
		check(r, 32'h0);
		xfer(1'b0, `LDO_CTRL_ADDR, 32'h0, r);
		check(r, ctrl_exp());
		// dropout status and request for every enable and priority
		for (int i = 0; i < 4; i++) begin
			m_ien = i % 2;
			m_pri = i / 2;
			xfer(1'b1, `LDO_IRQ_ADDR, i, r);
			xfer(1'b0, `LDO_IRQ_ADDR, 32'h0, r);
			check(r, i);
			dropout_cmp <= 1'b1;
			m_drop = 1;
			repeat (4) @(posedge hclk);
			check(dropout_irq, m_ien[0]);
			check(dropout_irq_priority, m_pri[0]);
			xfer(1'b0, `LDO_CTRL_ADDR, 32'h0, r);
			check(r, ctrl_exp());
			// handler turns the request off while dropout lasts
			xfer(1'b1, `LDO_IRQ_ADDR, 32'h0, r);
			repeat (2) @(posedge hclk);
			check(dropout_irq, 1'b0);
			dropout_cmp <= 1'b0;
			m_drop = 0;
			repeat (4) @(posedge hclk);
			xfer(1'b0, `LDO_CTRL_ADDR, 32'h0, r);
			check(r, ctrl_exp());
			// re-enable after the condition ended: nothing pending
			xfer(1'b1, `LDO_IRQ_ADDR, i, r);
			repeat (3) @(posedge hclk);
			check(dropout_irq, 1'b0);
		end
		// frozen clock enable with the bus idle: request must not move
		clk_en <= 1'b0;
		dropout_cmp <= 1'b1;
		repeat (6) @(posedge hclk);
		check(dropout_irq, 1'b0);
		clk_en <= 1'b1;
		repeat (4) @(posedge hclk);
		check(dropout_irq, 1'b1);
		dropout_cmp <= 1'b0;
		repeat (4) @(posedge hclk);
		check(dropout_irq, 1'b0);
		results();
	end
endmodule // tb
